/* lprp_seq.v */
// line-port reset, power-on-reset and power-down sequencer top
//
// Notes on behaviour
// - reset pin low powers down every port
// - reset ignores tx data, rx data low
// - reset clears range and loop everywhere
// - reset fall: pll nominal, resync after 130ns
// - reset reinitialises control port and filter
// - reset settings held until high and synced
// - power-on-reset sets clock pin input, pll not reset
// - clock present: clock pin becomes output
// - powered-down port grounds adc bitstream
// - powered-down port grounds both driver outputs
// - power down switches off dc reference
// - power down clears range and loop
// - power down puts tx filter low-power
// - interface, pll, level detect keep running
// - control port works outside reset whenever select is one
`timescale 1ns/1ps
`include "lprp_regs.vh"
module lprp_seq (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    por,
    input  wire                    reset_input_pin,
    input  wire                    serial_tx_data_in,
    output reg                     serial_rx_data_out,
    input  wire                    rx_data_core,
    output wire                    tx_data_core,
    output wire                    tx_data_valid,
    input  wire                    crystal_input,
    input  wire                    pll_clock_ok,
    input  wire                    master_clock_pin_i,
    output reg                     master_clock_pin_o,
    output reg                     master_clock_pin_oe_n,
    output reg                     pll_reset,
    output reg                     pll_resync,
    output reg                     filter_reset,
    input  wire                    control_port_select,
    output wire                    serial_control_port_en,
    output reg                     serial_control_port_reset,
    input  wire                    level_detect_in,
    output reg                     level_detect_out,
    input  wire [`LPRP_ADDR_W-1:0] reg_addr,
    input  wire [31:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [31:0]             reg_rdata,
    input  wire [3:0]              adc_bit_in,
    input  wire [3:0]              drv_a_in,
    input  wire [3:0]              drv_b_in,
    output wire [3:0]              adc_bitstream_out,
    output wire [3:0]              line_driver_a_out,
    output wire [3:0]              line_driver_b_out,
    output wire [3:0]              dc_ref_en,
    output wire [3:0]              range_en,
    output wire [3:0]              loop_en,
    output wire [3:0]              tx_filter_lowpwr,
    output wire                    activation_ok
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire res_pin_s;
    wire sdx_s;
    wire scs_s;
    wire xtal_s;
    wire pll_ok_s;

    lprp_sync2 #(.INIT(1'b1)) u_sync_res (
        .clk (clk), .rst (rst), .d (reset_input_pin), .q (res_pin_s)
    );
    lprp_sync2 #(.INIT(1'b0)) u_sync_sdx (
        .clk (clk), .rst (rst), .d (serial_tx_data_in), .q (sdx_s)
    );
    lprp_sync2 #(.INIT(1'b0)) u_sync_scs (
        .clk (clk), .rst (rst), .d (control_port_select), .q (scs_s)
    );
    lprp_sync2 #(.INIT(1'b0)) u_sync_xtal (
        .clk (clk), .rst (rst), .d (crystal_input), .q (xtal_s)
    );
    lprp_sync2 #(.INIT(1'b0)) u_sync_pll (
        .clk (clk), .rst (rst), .d (pll_clock_ok), .q (pll_ok_s)
    );

    // ------------------------------------------------------------
    // reset pin edge and sequencing state
    // ------------------------------------------------------------
    localparam ST_RUN    = 2'b00;
    localparam ST_RESET  = 2'b01;
    localparam ST_RESYNC = 2'b10;
    localparam ST_SYNC   = 2'b11;

    reg  [1:0]             state_r;
    reg  [1:0]             state_nxt;
    reg                    res_d_r;
    reg  [`LPRP_CNT_W-1:0] cnt_r;
    reg  [`LPRP_CNT_W-1:0] cnt_nxt;
    reg  [14:0]            act_cnt_r;
    reg                    act_ok_r;
    wire                   res_fall;
    wire                   in_reset;

    assign res_fall = res_d_r & ~res_pin_s;
    assign in_reset = (state_r != ST_RUN);

    always @* begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            ST_RUN: begin
                if (!res_pin_s) begin
                    state_nxt = ST_RESET;
                    cnt_nxt   = {`LPRP_CNT_W{1'b0}};
                end
            end
            ST_RESET: begin
                // pll resync delay counted from the falling edge
                if (cnt_r < `LPRP_RESYNC_CYC) begin
                    cnt_nxt = cnt_r + 1'b1;
                end
                if (res_pin_s && cnt_r >= `LPRP_RESYNC_CYC) begin
                    state_nxt = ST_SYNC;
                    cnt_nxt   = {`LPRP_CNT_W{1'b0}};
                end
            end
            ST_SYNC: begin
                // digital interface must resync before settings release
                if (!res_pin_s) begin
                    state_nxt = ST_RESET;
                    cnt_nxt   = {`LPRP_CNT_W{1'b0}};
                end else if (cnt_r >= `LPRP_SYNC_CYC - 1) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            default: begin
                state_nxt = ST_RESET;
                cnt_nxt   = {`LPRP_CNT_W{1'b0}};
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_r    <= ST_RESET;
            cnt_r      <= {`LPRP_CNT_W{1'b0}};
            res_d_r    <= 1'b1;
            pll_reset  <= 1'b1;
            pll_resync <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            res_d_r    <= res_pin_s;
            pll_reset  <= res_fall;
            pll_resync <= (state_r == ST_RESET) && (cnt_r == `LPRP_RESYNC_CYC - 1);
        end
    end

    // controller-side guard: 20 us after the reset pin rises
    always @(posedge clk) begin
        if (rst) begin
            act_cnt_r <= 15'h0000;
            act_ok_r  <= 1'b0;
        end else if (!res_pin_s) begin
            act_cnt_r <= 15'h0000;
            act_ok_r  <= 1'b0;
        end else if (act_cnt_r >= `LPRP_ACT_HOLD_CYC - 1) begin
            act_ok_r  <= 1'b1;
        end else begin
            act_cnt_r <= act_cnt_r + 1'b1;
        end
    end
    assign activation_ok = act_ok_r;

    // ------------------------------------------------------------
    // serial data, control port, filter, level detect
    // ------------------------------------------------------------
    assign tx_data_core  = in_reset ? 1'b0 : sdx_s;
    assign tx_data_valid = ~in_reset;
    // select high keeps control port alive regardless of power down
    assign serial_control_port_en = scs_s;

    always @(posedge clk) begin
        if (rst) begin
            serial_rx_data_out        <= 1'b0;
            serial_control_port_reset <= 1'b1;
            filter_reset              <= 1'b1;
            level_detect_out          <= 1'b0;
        end else begin
            serial_rx_data_out        <= in_reset ? 1'b0 : rx_data_core;
            serial_control_port_reset <= in_reset;
            filter_reset              <= in_reset;
            level_detect_out          <= level_detect_in;
        end
    end

    // ------------------------------------------------------------
    // power-on-reset and master clock pin direction
    // ------------------------------------------------------------
    reg [4:0] lock_cnt_r;

    always @(posedge clk) begin
        if (rst || por) begin
            lock_cnt_r            <= 5'h00;
            master_clock_pin_oe_n <= 1'b1;
            master_clock_pin_o    <= 1'b0;
        end else begin
            if (!master_clock_pin_oe_n) begin
                master_clock_pin_o <= ~master_clock_pin_o;
            end
            // either pll or external crystal counts as a clock source
            if (pll_ok_s || xtal_s) begin
                if (lock_cnt_r >= `LPRP_MCLK_LOCK_CYC - 1) begin
                    master_clock_pin_oe_n <= 1'b0;
                end else begin
                    lock_cnt_r <= lock_cnt_r + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [3:0] pwr_r;
    reg [7:0] func_r;

    function [3:0] port_mask;
        input [1:0] idx;
        begin
            port_mask = 4'h1 << idx;
        end
    endfunction

    always @(posedge clk) begin
        if (rst) begin
            pwr_r  <= `LPRP_PWR_RST;
            func_r <= `LPRP_FUNC_RST;
        end else if (in_reset) begin
            pwr_r  <= `LPRP_PWR_RST;
            func_r <= `LPRP_FUNC_RST;
        end else if (reg_wr) begin
            if (reg_addr == `LPRP_OFF_PWR_CTRL) begin
                pwr_r <= reg_wdata[3:0];
            end else if (reg_addr == `LPRP_OFF_FUNC_CTRL) begin
                func_r <= reg_wdata[7:0];
            end else if (reg_addr == `LPRP_OFF_PORT_CMD) begin
                if (reg_wdata[`LPRP_CMD_UP_BIT]) begin
                    pwr_r <= pwr_r | port_mask(reg_wdata[1:0]);
                end else begin
                    pwr_r <= pwr_r & ~port_mask(reg_wdata[1:0]);
                end
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            if (reg_addr == `LPRP_OFF_PWR_CTRL) begin
                reg_rdata <= {28'h000_0000, pwr_r};
            end else if (reg_addr == `LPRP_OFF_FUNC_CTRL) begin
                reg_rdata <= {24'h00_0000, func_r};
            end else if (reg_addr == `LPRP_OFF_STATUS) begin
                reg_rdata <= {24'h00_0000, pwr_r, ~master_clock_pin_oe_n,
                              act_ok_r, (state_r == ST_RUN), in_reset};
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // per-port gating
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `LPRP_NPORTS; gi = gi + 1) begin : g_port
            lprp_port_ctrl u_port (
                .clk               (clk),
                .rst               (rst),
                .power_up          (pwr_r[gi] & ~in_reset),
                .range_req         (func_r[`LPRP_RANGE_LSB + gi]),
                .loop_req          (func_r[`LPRP_LOOP_LSB + gi]),
                .adc_bit_in        (adc_bit_in[gi]),
                .drv_a_in          (drv_a_in[gi]),
                .drv_b_in          (drv_b_in[gi]),
                .adc_bitstream_out (adc_bitstream_out[gi]),
                .line_driver_a_out (line_driver_a_out[gi]),
                .line_driver_b_out (line_driver_b_out[gi]),
                .dc_ref_en         (dc_ref_en[gi]),
                .range_en          (range_en[gi]),
                .loop_en           (loop_en[gi]),
                .tx_filter_lowpwr  (tx_filter_lowpwr[gi])
            );
        end
    endgenerate
endmodule // lprp_seq

/* lprp_regs.vh */
// constants for the line-port reset and power-down sequencer
`ifndef LPRP_REGS_VH
`define LPRP_REGS_VH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define LPRP_NPORTS          4
`define LPRP_PORT_W          2

// ------------------------------------------------------------
// timing (clk 50 MHz, 20 ns)
// ------------------------------------------------------------
`define LPRP_CLK_PERIOD_NS   20
`define LPRP_RESYNC_NS       130
// least time rounds up
`define LPRP_RESYNC_CYC      ((`LPRP_RESYNC_NS + `LPRP_CLK_PERIOD_NS - 1) / `LPRP_CLK_PERIOD_NS)
`define LPRP_ACT_HOLD_US     20
`define LPRP_ACT_HOLD_CYC    ((`LPRP_ACT_HOLD_US * 1000 + `LPRP_CLK_PERIOD_NS - 1) / `LPRP_CLK_PERIOD_NS)
`define LPRP_SYNC_CYC        8
`define LPRP_MCLK_LOCK_CYC   16
`define LPRP_CNT_W           10

// ------------------------------------------------------------
// register map (word offsets = byte addresses)
// ------------------------------------------------------------
`define LPRP_ADDR_W          8
`define LPRP_OFF_PWR_CTRL    8'h00
`define LPRP_OFF_FUNC_CTRL   8'h04
`define LPRP_OFF_STATUS      8'h08
`define LPRP_OFF_PORT_CMD    8'h0C

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define LPRP_PWR_RST         4'h0
`define LPRP_FUNC_RST        8'h00
`define LPRP_RANGE_LSB       0
`define LPRP_LOOP_LSB        4
`define LPRP_CMD_PORT_LSB    0
`define LPRP_CMD_UP_BIT      2
`define LPRP_ST_INRESET_BIT  0
`define LPRP_ST_SYNCED_BIT   1
`define LPRP_ST_ACTOK_BIT    2
`define LPRP_ST_MCLKOUT_BIT  3
`define LPRP_ST_PWR_LSB      4

`endif

/* lprp_sync2.v */
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module lprp_sync2 #(
    parameter INIT = 1'b0
) (
    input  wire clk,
    input  wire rst,
    input  wire d,
    output wire q
);
    reg meta_r;
    reg sync_r;

    always @(posedge clk) begin
        if (rst) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= d;
            sync_r <= meta_r;
        end
    end

    assign q = sync_r;
endmodule // lprp_sync2

/* lprp_port_ctrl.v */
// per line-port power-down gating of analog-side outputs
`timescale 1ns/1ps
module lprp_port_ctrl (
    input  wire clk,
    input  wire rst,
    input  wire power_up,
    input  wire range_req,
    input  wire loop_req,
    input  wire adc_bit_in,
    input  wire drv_a_in,
    input  wire drv_b_in,
    output reg  adc_bitstream_out,
    output reg  line_driver_a_out,
    output reg  line_driver_b_out,
    output reg  dc_ref_en,
    output reg  range_en,
    output reg  loop_en,
    output reg  tx_filter_lowpwr
);
    always @(posedge clk) begin
        if (rst) begin
            adc_bitstream_out <= 1'b0;
            line_driver_a_out <= 1'b0;
            line_driver_b_out <= 1'b0;
            dc_ref_en         <= 1'b0;
            range_en          <= 1'b0;
            loop_en           <= 1'b0;
            tx_filter_lowpwr  <= 1'b1;
        end else begin
            adc_bitstream_out <= power_up & adc_bit_in;
            line_driver_a_out <= power_up & drv_a_in;
            line_driver_b_out <= power_up & drv_b_in;
            dc_ref_en         <= power_up;
            range_en          <= power_up & range_req;
            loop_en           <= power_up & loop_req;
            tx_filter_lowpwr  <= ~power_up;
        end
    end
endmodule // lprp_port_ctrl

/* lprp_seq_monitor.sv */
// concurrent checks on the line-port sequencer top ports
`timescale 1ns/1ps
module lprp_seq_monitor (
    input wire       clk,
    input wire       rst,
    input wire       por,
    input wire       reset_input_pin,
    input wire       crystal_input,
    input wire       pll_clock_ok,
    input wire       control_port_select,
    input wire       serial_control_port_en,
    input wire       serial_rx_data_out,
    input wire       master_clock_pin_oe_n,
    input wire       pll_reset,
    input wire       pll_resync,
    input wire       filter_reset,
    input wire       serial_control_port_reset,
    input wire [3:0] adc_bitstream_out,
    input wire [3:0] line_driver_a_out,
    input wire [3:0] line_driver_b_out,
    input wire [3:0] dc_ref_en,
    input wire [3:0] range_en,
    input wire [3:0] loop_en,
    input wire [3:0] tx_filter_lowpwr
);
    // ----------
    // clock-present run length, saturating so it never wraps
    // ----------
    reg [4:0] clk_cnt_r;
    always @(posedge clk) begin
        if (rst || por || !(crystal_input || pll_clock_ok))
            clk_cnt_r <= 5'h00;
        else if (clk_cnt_r != 5'h1f)
            clk_cnt_r <= clk_cnt_r + 5'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------
    // properties
    // ----------
    chk_ports_down: assert property (!reset_input_pin [*7] |->
        dc_ref_en == 4'h0 && tx_filter_lowpwr == 4'hf && (range_en | loop_en | adc_bitstream_out
        | line_driver_a_out | line_driver_b_out) == 4'h0) else $error("ports not down in reset");
    chk_rx_low: assert property (!reset_input_pin [*7] |-> !serial_rx_data_out)
        else $error("rx data not low in reset");
    chk_pll_resync: assert property ($rose(pll_reset) && !por |-> ##[6:9] pll_resync)
        else $error("no resync after pll reset");
    chk_hold_sync: assert property (!reset_input_pin [*6] ##1 reset_input_pin |->
        (filter_reset && serial_control_port_reset) [*8]) else $error("reset state left early");
    chk_pwr_gate: assert property (tx_filter_lowpwr == ~dc_ref_en && ((range_en | loop_en |
        adc_bitstream_out | line_driver_a_out | line_driver_b_out) & ~dc_ref_en) == 4'h0)
        else $error("down port not gated");
    chk_clk_out: assert property (clk_cnt_r == 5'h1f |-> !master_clock_pin_oe_n)
        else $error("clock pin not driven");
    chk_por_in: assert property (por |=> master_clock_pin_oe_n)
        else $error("clock pin driven in por");
    chk_sel_en: assert property (!rst ##1 !rst ##1 !rst |->
        serial_control_port_en == $past(control_port_select, 2)) else $error("control port enable wrong");
endmodule // lprp_seq_monitor

bind lprp_seq lprp_seq_monitor u_mon (.clk(clk), .rst(rst), .por(por), .reset_input_pin(reset_input_pin),
    .crystal_input(crystal_input), .pll_clock_ok(pll_clock_ok), .control_port_select(control_port_select),
    .serial_control_port_en(serial_control_port_en), .serial_rx_data_out(serial_rx_data_out),
    .master_clock_pin_oe_n(master_clock_pin_oe_n), .pll_reset(pll_reset), .pll_resync(pll_resync),
    .filter_reset(filter_reset), .serial_control_port_reset(serial_control_port_reset),
    .adc_bitstream_out(adc_bitstream_out), .line_driver_a_out(line_driver_a_out),
    .line_driver_b_out(line_driver_b_out), .dc_ref_en(dc_ref_en), .range_en(range_en),
    .loop_en(loop_en), .tx_filter_lowpwr(tx_filter_lowpwr));

/* lprp_ctrl_model.sv */
// controller-side model: reset pin, tx data line, control select
`timescale 1ns/1ps
module lprp_ctrl_model (
    input  wire clk,
    input  wire por,
    input  wire want_reset,
    input  wire want_select,
    input  wire act_ok,
    input  wire tx_bit,
    output reg  reset_input_pin,
    output reg  serial_tx_data_in,
    output reg  control_port_select
);
    initial begin
        reset_input_pin = 1'b1;
        serial_tx_data_in = 1'b0;
        control_port_select = 1'b1;
    end
    // no real data before activation is allowed; line just wiggles
    always @(posedge clk) begin
        reset_input_pin <= por | ~want_reset;
        serial_tx_data_in <= act_ok ? tx_bit : ~serial_tx_data_in;
        control_port_select <= want_select;
    end
endmodule // lprp_ctrl_model

/* lprp_seq_tb.sv */
// self-checking bench for the line-port sequencer
`timescale 1ns/1ps
`include "lprp_regs.vh"
module lprp_seq_tb;
    reg         clk, rst, por, want_reset, want_select, tx_bit, rx_data_core, up_bit;
    reg         crystal_input, pll_clock_ok, level_detect_in, reg_wr, reg_rd;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, rd_v;
    reg  [3:0]  adc_bit_in, drv_a_in, drv_b_in, pw, fr, fl;
    reg  [1:0]  sel_port;
    wire        reset_input_pin, serial_tx_data_in, control_port_select, serial_rx_data_out;
    wire        tx_data_valid, master_clock_pin_oe_n, serial_control_port_en, activation_ok;
    wire        level_detect_out, tx_data_core;
    wire [31:0] reg_rdata;
    wire [3:0]  adc_bitstream_out, line_driver_a_out, line_driver_b_out, dc_ref_en, range_en, loop_en;
    wire [3:0]  tx_filter_lowpwr;
    integer     err_count, n_tests, cyc, i;
    lprp_seq u_dut (.clk(clk), .rst(rst), .por(por), .reset_input_pin(reset_input_pin),
        .serial_tx_data_in(serial_tx_data_in), .serial_rx_data_out(serial_rx_data_out),
        .rx_data_core(rx_data_core), .tx_data_core(tx_data_core), .tx_data_valid(tx_data_valid),
        .crystal_input(crystal_input), .pll_clock_ok(pll_clock_ok), .master_clock_pin_i(1'b0),
        .master_clock_pin_o(), .master_clock_pin_oe_n(master_clock_pin_oe_n), .pll_reset(),
        .pll_resync(), .filter_reset(), .control_port_select(control_port_select),
        .serial_control_port_en(serial_control_port_en), .serial_control_port_reset(),
        .level_detect_in(level_detect_in), .level_detect_out(level_detect_out), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_bit_in(adc_bit_in), .drv_a_in(drv_a_in), .drv_b_in(drv_b_in),
        .adc_bitstream_out(adc_bitstream_out), .line_driver_a_out(line_driver_a_out),
        .line_driver_b_out(line_driver_b_out), .dc_ref_en(dc_ref_en), .range_en(range_en),
        .loop_en(loop_en), .tx_filter_lowpwr(tx_filter_lowpwr), .activation_ok(activation_ok));
    lprp_ctrl_model u_ctrl (.clk(clk), .por(por), .want_reset(want_reset), .want_select(want_select),
        .act_ok(activation_ok), .tx_bit(tx_bit), .reset_input_pin(reset_input_pin),
        .serial_tx_data_in(serial_tx_data_in), .control_port_select(control_port_select));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------
    // helpers
    // ----------
    function [15:0] exp_ports(input [3:0] p, input [7:0] f);
        exp_ports = {~p, f[7:4] & p, f[3:0] & p, p};
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task wait_run;
        begin
            rd_v = 32'h0000_0000;
            for (i = 0; i < 200 && rd_v[1] !== 1'b1; i = i + 1)
                rd(`LPRP_OFF_STATUS, rd_v);
            check(rd_v[1:0], 2'b10);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // long enough for the 1000-cycle activation wait and all loops
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            tally_and_finish;
        end
    end
    // ----------
    // main sequence
    // ----------
    initial begin
        {rst, por, crystal_input, want_select} = 4'hf;
        {want_reset, tx_bit, rx_data_core, pll_clock_ok, level_detect_in, reg_wr, reg_rd} = 7'h00;
        {reg_addr, reg_wdata, adc_bit_in, drv_a_in, drv_b_in} = 52'h0;
        err_count = 0;
        n_tests = 0;
        cyc = 0;
        rd_v = $urandom(28);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        wait_run;
        for (i = 0; i < 20; i = i + 4)
            if (i != 8) begin
                rd(i[7:0], rd_v); // unmapped 0x10 and write-only command read zero
                check(rd_v, 32'h0000_0000);
            end
        for (i = 0; i < 24; i = i + 1) begin
            pw = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : $urandom;
            fr = $urandom;
            fl = $urandom;
            adc_bit_in <= $urandom;
            drv_a_in <= $urandom;
            drv_b_in <= $urandom;
            {rx_data_core, level_detect_in, tx_bit, pll_clock_ok, want_select} <= $urandom;
            wr(`LPRP_OFF_PWR_CTRL, {28'h0, pw});
            wr(`LPRP_OFF_FUNC_CTRL, {24'h0, fl, fr});
            repeat (2) @(posedge clk);
            #1 check({tx_filter_lowpwr, loop_en, range_en, dc_ref_en}, exp_ports(pw, {fl, fr}));
            check({adc_bitstream_out, line_driver_a_out, line_driver_b_out},
                {adc_bit_in & pw, drv_a_in & pw, drv_b_in & pw});
            check({serial_rx_data_out, level_detect_out, tx_data_valid, serial_control_port_en},
                {rx_data_core, level_detect_in, 1'b1, want_select});
            rd(`LPRP_OFF_STATUS, rd_v);
            check({rd_v[7:3], master_clock_pin_oe_n}, {pw, 2'b10});
            sel_port = $urandom;
            up_bit = $urandom;
            wr(`LPRP_OFF_PORT_CMD, {29'h0, up_bit, sel_port});
            pw[sel_port] = up_bit;
            repeat (2) @(posedge clk);
            #1 check(dc_ref_en, pw);
        end
        want_select <= 1'b1;
        rx_data_core <= 1'b1;
        want_reset <= 1'b1;
        repeat (8) @(posedge clk);
        wr(`LPRP_OFF_PWR_CTRL, 32'h0000_000f);
        repeat (4) @(posedge clk);
        #1 check({tx_filter_lowpwr, loop_en, range_en, dc_ref_en}, exp_ports(4'h0, 8'h00));
        check({serial_rx_data_out, tx_data_valid}, 2'b00);
        rd(`LPRP_OFF_STATUS, rd_v);
        check(rd_v[1:0], 2'b01);
        want_reset <= 1'b0;
        wait_run;
        rd(`LPRP_OFF_PWR_CTRL, rd_v);
        check(rd_v, 32'h0000_0000);
        check(activation_ok, 1'b0);
        repeat (1000) @(posedge clk);
        #1 check(activation_ok, 1'b1);
        check(tx_data_core, tx_bit);
        por <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check({master_clock_pin_oe_n, reset_input_pin}, 2'b11);
        por <= 1'b0;
        tally_and_finish;
    end
endmodule // lprp_seq_tb
